// *** ebrpr_mem.sv ***
// shared types and constants, and the dual-port storage array
package ebrpr_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 36;
  localparam int NUM_PORTS = 2;
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam logic [DATA_W-1:0] RDATA_RESET = 36'h0;
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int FMAX_PERIOD_NS = 20;
  localparam int QUIET_CYCLES_RAW =
    (FMAX_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int QUIET_CYCLES = (QUIET_CYCLES_RAW < 1) ? 1 : QUIET_CYCLES_RAW;

  typedef struct packed {
    logic en;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebrpr_req_t;
endpackage

`timescale 1ns/1ps
`default_nettype none

module ebrpr_mem
  import ebrpr_pkg::*;
(
  input wire logic clock,
  input wire logic global_reset_n,
  input wire ebrpr_req_t req [NUM_PORTS],
  input wire logic write_through [NUM_PORTS],
  input wire logic clear [NUM_PORTS],
  output logic [DATA_W-1:0] rdata_q [NUM_PORTS]
);
  logic [DATA_W-1:0] array_q [2**ADDR_W];

  // port b written first so that port a wins a same-address collision
  always_ff @(posedge clock) begin
    for (int p = NUM_PORTS - 1; p >= 0; p--) begin
      if (req[p].en && req[p].we) begin
        array_q[req[p].addr] <= req[p].wdata;
      end
    end
  end

  // the output latches; global reset is always asynchronous
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    always_ff @(posedge clock or negedge global_reset_n) begin
      if (!global_reset_n) begin
        rdata_q[p] <= RDATA_RESET;
      end else if (clear[p]) begin
        rdata_q[p] <= RDATA_RESET;
      end else if (req[p].en && req[p].we && write_through[p]) begin
        rdata_q[p] <= req[p].wdata;
      end else if (req[p].en && !req[p].we) begin
        rdata_q[p] <= array_q[req[p].addr];
      end
    end
  end
endmodule // ebrpr_mem

`default_nettype wire

// *** ebrpr_top.sv ***
// dual-port block ram output latches with reset sequencing
// What this block does
// [RQ1] With write-through on, a write puts its data on that port's read output.
// [RQ2] Write-through works at every port data width; the code has one fixed width, DATA_W of 36 bits.
// [RQ3] Each port's read data sits in output latches cleared async or sync.
// [RQ4] Port a local reset clears only port a; port b reset only port b.
// [RQ5] The global reset clears the output latches of both ports together.
// [RQ6] Fabric holds all clock enables low a cycle before and after async reset.
// [RQ7] The global reset acts asynchronously in every configuration.
// [RQ8] With enables active, async reset may move only after steady clocks.
// [RQ9] Fabric releases reset in time for the synchronous reset setup.
// [RQ10] A cleared latch reads zero until the next read or write-through load.
`timescale 1ns/1ps
`default_nettype none

module ebrpr_top
  import ebrpr_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic global_reset_n,
  input wire ebrpr_req_t port_a_req,
  input wire ebrpr_req_t port_b_req,
  input wire logic port_a_output_reset,
  input wire logic port_b_output_reset,
  input wire logic write_through_a,
  input wire logic write_through_b,
  input wire logic local_reset_async,
  output logic [DATA_W-1:0] port_a_rdata,
  output logic [DATA_W-1:0] port_b_rdata,
  output logic reset_order_error_a,
  output logic reset_order_error_b,
  output logic reset_order_error_global
);
  typedef struct packed {
    logic gsr_meta;
    logic gsr_sync;
    logic gsr_prev;
    logic rst_a_prev;
    logic rst_b_prev;
    logic [2:0] ce_hist;
    logic rel_a;
    logic rel_b;
    logic rel_g;
    logic err_a;
    logic err_b;
    logic err_g;
  } ebrpr_state_t;

  ebrpr_state_t state_q;
  ebrpr_state_t state_d;

  ebrpr_req_t req [NUM_PORTS];
  logic wt [NUM_PORTS];
  logic clear [NUM_PORTS];
  logic [DATA_W-1:0] latch_q [NUM_PORTS];
  logic any_ce;

  // the enable-quiet checks only watch; the ram itself cannot refuse a reset
  function automatic logic order_bad(
    input logic rise,
    input logic fall,
    input logic rel,
    input logic ce_prev,
    input logic ce_now
  );
    order_bad = (rise && (ce_prev || ce_now)) || (fall && ce_now) ||
                (rel && ce_now);
  endfunction

  assign req[PORT_A] = port_a_req;
  assign req[PORT_B] = port_b_req;
  assign wt[PORT_A] = write_through_a; // RQ1 RQ2
  assign wt[PORT_B] = write_through_b; // RQ1 RQ2
  // the latch clears on the edge in both modes; async mode also masks now
  assign clear[PORT_A] = port_a_output_reset; // RQ3 RQ4
  assign clear[PORT_B] = port_b_output_reset; // RQ3 RQ4
  assign any_ce = port_a_req.en || port_b_req.en;

  ebrpr_mem u_mem (
    .clock(clock),
    .global_reset_n(global_reset_n), // RQ5 RQ7
    .req(req),
    .write_through(wt),
    .clear(clear),
    .rdata_q(latch_q)
  );

  // async local reset forces zero at once instead of waiting for an edge
  assign port_a_rdata = (local_reset_async && port_a_output_reset) ?
                        RDATA_RESET : latch_q[PORT_A]; // RQ3 RQ4 RQ10
  assign port_b_rdata = (local_reset_async && port_b_output_reset) ?
                        RDATA_RESET : latch_q[PORT_B]; // RQ3 RQ4 RQ10

  always_comb begin
    logic g_on;
    logic g_rise;
    logic g_fall;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    g_on = 1'b0;
    g_rise = 1'b0;
    g_fall = 1'b0;
    a_rise = 1'b0;
    a_fall = 1'b0;
    b_rise = 1'b0;
    b_fall = 1'b0;
    state_d = state_q;
    state_d.gsr_meta = global_reset_n;
    state_d.gsr_sync = state_q.gsr_meta;
    g_on = !state_q.gsr_sync;
    g_rise = g_on && !state_q.gsr_prev;
    g_fall = !g_on && state_q.gsr_prev;
    a_rise = local_reset_async && port_a_output_reset && !state_q.rst_a_prev;
    a_fall = local_reset_async && !port_a_output_reset && state_q.rst_a_prev;
    b_rise = local_reset_async && port_b_output_reset && !state_q.rst_b_prev;
    b_fall = local_reset_async && !port_b_output_reset && state_q.rst_b_prev;
    state_d.gsr_prev = g_on;
    state_d.rst_a_prev = port_a_output_reset;
    state_d.rst_b_prev = port_b_output_reset;
    state_d.ce_hist = {state_q.ce_hist[1:0], any_ce};
    state_d.rel_a = a_fall;
    state_d.rel_b = b_fall;
    state_d.rel_g = g_fall;
    // enables must be quiet one cycle around every async edge
    if (order_bad(a_rise, a_fall, state_q.rel_a, state_q.ce_hist[0],
                  any_ce)) begin // RQ6 RQ8 RQ9
      state_d.err_a = 1'b1;
    end
    if (order_bad(b_rise, b_fall, state_q.rel_b, state_q.ce_hist[0],
                  any_ce)) begin // RQ6 RQ8 RQ9
      state_d.err_b = 1'b1;
    end
    // global edges arrive two cycles late, so compare delayed enables
    if (order_bad(g_rise, g_fall, state_q.rel_g, state_q.ce_hist[2],
                  state_q.ce_hist[1])) begin // RQ6 RQ8 RQ9
      state_d.err_g = 1'b1;
    end
  end

  // monitor state survives the global reset so misuse of it is recorded
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= '0;
      state_q.gsr_meta <= 1'b1;
      state_q.gsr_sync <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign reset_order_error_a = state_q.err_a;
  assign reset_order_error_b = state_q.err_b;
  assign reset_order_error_global = state_q.err_g;

  sequence s_wt_write_a;
    port_a_req.en && port_a_req.we && write_through_a &&
    !port_a_output_reset;
  endsequence

  sequence s_wt_write_b;
    port_b_req.en && port_b_req.we && write_through_b &&
    !port_b_output_reset;
  endsequence

  sequence s_quiet_after_a;
    ##1 (global_reset_n && !port_a_output_reset);
  endsequence

  sequence s_quiet_after_b;
    ##1 (global_reset_n && !port_b_output_reset);
  endsequence

  a_wt_data_a: assert property ( // RQ1
    @(posedge clock) disable iff (reset)
    s_wt_write_a ##0 global_reset_n ##0 s_quiet_after_a
    |-> port_a_rdata == $past(port_a_req.wdata))
    else $error("port a write-through data missing");

  a_wt_data_b: assert property ( // RQ1
    @(posedge clock) disable iff (reset)
    s_wt_write_b ##0 global_reset_n ##0 s_quiet_after_b
    |-> port_b_rdata == $past(port_b_req.wdata))
    else $error("port b write-through data missing");

  a_sync_clear_a: assert property ( // RQ3
    @(posedge clock) disable iff (reset)
    (port_a_output_reset && !local_reset_async) |=>
    latch_q[PORT_A] == RDATA_RESET)
    else $error("port a latch not cleared by sync reset");

  a_async_mask_b: assert property ( // RQ3
    @(posedge clock) disable iff (reset)
    (local_reset_async && port_b_output_reset) |->
    port_b_rdata == RDATA_RESET ##1 latch_q[PORT_B] == RDATA_RESET)
    else $error("port b output not zero under async reset");

  a_port_isolation: assert property ( // RQ4
    @(posedge clock) disable iff (reset)
    (port_a_output_reset && !port_b_output_reset && !port_b_req.en &&
     global_reset_n) ##1 (global_reset_n && !port_b_output_reset)
    |-> $stable(port_b_rdata))
    else $error("port a reset disturbed port b");

  a_global_both: assert property ( // RQ5
    @(posedge clock) disable iff (reset)
    !global_reset_n |-> (port_a_rdata == RDATA_RESET &&
                         port_b_rdata == RDATA_RESET))
    else $error("global reset left a port uncleared");

  a_global_async: assert property ( // RQ7
    @(negedge clock) disable iff (reset)
    !global_reset_n |->
    (latch_q[PORT_A] == RDATA_RESET && latch_q[PORT_B] == RDATA_RESET))
    else $error("global reset did not act without a clock edge");

  a_zero_until_load: assert property ( // RQ10
    @(posedge clock) disable iff (reset)
    ($fell(port_a_output_reset) && global_reset_n) |->
    port_a_rdata == RDATA_RESET)
    else $error("port a latch not zero after reset release");
endmodule // ebrpr_top

`default_nettype wire

// *** ebrpr_fabric.sv ***
// fabric model that sequences the global reset around quiet enables
`timescale 1ns/1ps
`default_nettype none

module ebrpr_fabric (
  input wire logic clock,
  input wire logic go,
  output logic global_reset_n,
  output logic en_ok
);
  logic [2:0] step_q = 3'h0;

  // go must be a one-cycle pulse, a held go would restart the sequence
  always_ff @(posedge clock) begin
    if (step_q == 3'h5) step_q <= 3'h0;
    else if (step_q != 3'h0 || go) step_q <= step_q + 3'h1;
  end
  assign en_ok = (step_q == 3'h0) && !go;
  // release lands just after an edge, a full period before the next one
  assign global_reset_n = !(step_q inside {3'h2, 3'h3});
endmodule // ebrpr_fabric
`default_nettype wire

// *** test_block_ram_port_reset.sv ***
// self-checking bench for the ram output latches and reset sequencing
`timescale 1ns/1ps
`default_nettype none

module test_block_ram_port_reset
  import ebrpr_pkg::*;
;
  typedef struct {int cyc; int p; logic [35:0] v;} ebrpr_note_t;
  logic clock = 0, reset = 1, go = 0, en_ok, global_reset_n;
  logic rsa = 0, rsb = 0, wta = 1, wtb = 1, lra = 0, rude = 0;
  logic ea, eb, eg;
  logic [35:0] pa, pb, mem [int], last [2];
  ebrpr_req_t ra = '0, rb = '0, ra_m, rb_m;
  logic [31:0] seed = 32'h2AEE;
  int cyc = 0, n_mismatch = 0, compares = 0;
  logic [8:0] ads [$];
  ebrpr_note_t q [$], n;

  ebrpr_fabric i_ebrpr_fabric (.clock(clock), .go(go),
    .global_reset_n(global_reset_n), .en_ok(en_ok));
  ebrpr_top i_ebrpr_top (.clock(clock), .reset(reset),
    .global_reset_n(global_reset_n), .port_a_req(ra_m), .port_b_req(rb_m),
    .port_a_output_reset(rsa), .port_b_output_reset(rsb),
    .write_through_a(wta), .write_through_b(wtb), .local_reset_async(lra),
    .port_a_rdata(pa), .port_b_rdata(pb), .reset_order_error_a(ea),
    .reset_order_error_b(eb), .reset_order_error_global(eg));

  initial forever #10 clock = !clock;
  always @(posedge clock) cyc <= cyc + 1;
  always_comb begin
    ra_m = ra;
    rb_m = rb;
    ra_m.en = ra.en & (en_ok | rude);
    rb_m.en = rb.en & (en_ok | rude);
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk36(input string nm, input logic [35:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, g);
    chk36(nm, {35'h0, e}, {35'h0, g});
  endtask

  // one access on port p, the other port idles in the same cycle
  task automatic acc(input int p, input logic we, input logic [8:0] ad);
    ebrpr_req_t r;
    logic [35:0] e;
    @(posedge clock);
    seed = lfsr(seed);
    r = '{en: 1'b1, we: we, addr: ad, wdata: {seed[3:0], seed}};
    e = we ? ((p ? wtb : wta) ? r.wdata : last[p]) : mem[ad];
    if (we) mem[ad] = r.wdata;
    last[p] = e;
    if (p == 0) begin
      ra <= r;
      rb.en <= 1'b0;
    end else begin
      rb <= r;
      ra.en <= 1'b0;
    end
    q.push_back('{cyc + 2, p, e});
  endtask

  task automatic idle(input int k);
    @(posedge clock);
    ra.en <= 1'b0;
    rb.en <= 1'b0;
    repeat (k) @(posedge clock);
  endtask

  task automatic note_both();
    q.push_back('{cyc + 2, 0, last[0]});
    q.push_back('{cyc + 2, 1, last[1]});
  endtask

  always @(negedge clock)
    while (q.size() > 0 && q[0].cyc == cyc) begin
      n = q.pop_front();
      chk36(n.p ? "port_b_rdata" : "port_a_rdata", n.v,
        n.p ? pb : pa);
    end

  task automatic test_done();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clock);
    n_mismatch++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      ads.push_back({i[0], seed[7:0]});
      acc(i % 2, 1'b1, ads[i]);
    end
    foreach (ads[i]) acc(1 - (i % 2), 1'b0, ads[i]);
    idle(3);
    rsa <= 1'b1;
    last[0] = '0;
    note_both();
    @(posedge clock);
    rsa <= 1'b0;
    acc(0, 1'b0, ads[2]);
    lra <= 1'b1;
    idle(2);
    rsb <= 1'b1;
    #2 chk36("port_b_rdata", '0, pb);
    last[1] = '0;
    note_both();
    @(posedge clock);
    rsb <= 1'b0;
    idle(2);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    #2 chk36("port_a_rdata", '0, pa);
    chk36("port_b_rdata", '0, pb);
    repeat (6) @(posedge clock);
    wta <= 1'b0;
    wtb <= 1'b0;
    last = '{default: '0};
    acc(0, 1'b1, ads[0]);
    acc(1, 1'b1, ads[1]);
    acc(1, 1'b0, ads[0]);
    idle(4);
    chk1("reset_order_error_global", 1'b0, eg);
    chk1("reset_order_error_a", 1'b0, ea);
    ra <= '{en: 1'b1, we: 1'b0, addr: ads[0], wdata: '0};
    rsa <= 1'b1;
    repeat (3) @(posedge clock);
    ra.en <= 1'b0;
    rsa <= 1'b0;
    #2 chk1("reset_order_error_a", 1'b1, ea);
    chk1("reset_order_error_b", 1'b0, eb);
    idle(3);
    // enables left on across a global reset, sync local mode
    rude <= 1'b1;
    lra <= 1'b0;
    ra <= '{en: 1'b1, we: 1'b0, addr: ads[1], wdata: '0};
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (8) @(posedge clock);
    ra.en <= 1'b0;
    rude <= 1'b0;
    #2 chk1("reset_order_error_global", 1'b1, eg);
    idle(2);
    chk1("notes_left", 1'b0, q.size() != 0);
    test_done();
  end
endmodule // test_block_ram_port_reset
`default_nettype wire
